// ===== core/cell_cfg_consts.svh
// offsets, field positions, reset values and widths of the cell configuration slice
`ifndef CELL_CFG_CONSTS_SVH
`define CELL_CFG_CONSTS_SVH

`define POLARITY_OFS        2'h0
`define DATA_ONE_SEL_OFS    2'h1
`define DATA_TWO_SEL_OFS    2'h2
`define OUT_INV_BIT         7
`define GATE_INV_MSB        3
`define SEL_MSB             5
`define OUT_INV_RESET       1'b0
`define GATE_INV_RESET      4'h0
`define SEL_RESET           6'h00

`endif

// ===== core/cell_cfg_pkg.sv
// types of the cell configuration slice
package cell_cfg_pkg;
  typedef logic [1:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
  typedef logic [5:0] source_sel_t;
endpackage

// ===== core/cell_polarity_select.sv
// polarity controls and data one/two source selectors of a logic cell
// Function
// R1: each gate invert bit set inverts that gate output, clear passes it.
// R2: first selector holds six-bit field 5..0 choosing data channel one source.
// R3: second selector holds six-bit field 5..0 choosing data channel two source.
// R4: unimplemented selector bits 7..6 and polarity bits 6..4 read zero, ignore writes.
// R5: output invert clears on every reset; gate inverts and selectors survive warm resets.
// R6: polarity bit 7 set inverts logic function result before cell output.
// R7: selector codes beyond implemented sources drive data channel low.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`include "cell_cfg_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module cell_polarity_select #(
  parameter int NUM_SOURCES = 64
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rstn_i,
  input  wire logic                      cold_rstn_i,
  input  wire cell_cfg_pkg::reg_addr_t   addr_i,
  input  wire cell_cfg_pkg::reg_data_t   wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output cell_cfg_pkg::reg_data_t        rdata_o,
  input  wire logic [NUM_SOURCES-1:0]    sources_i,
  output logic                           data_one_o,
  output logic                           data_two_o,
  input  wire logic [3:0]                gate_raw_i,
  output logic [3:0]                     gate_pol_o,
  input  wire logic                      func_result_i,
  output logic                           cell_result_o
);
  import cell_cfg_pkg::*;

  // behaviour notes for users of this slice:
  // - two resets reach it. rstn_i is every reset of the device and
  //   clears only the output invert bit and the read data register.
  //   cold_rstn_i is the power-on and brown-out reset; it must be
  //   asserted together with rstn_i and it also clears the gate
  //   inverts and both selectors.
  // - after a cold reset the gate inverts and selectors are zero.
  //   software should not rely on that and should program them
  //   before enabling the cell, since the device treats them as
  //   unknown at that point.
  // - a write takes effect at the edge that samples the strobe, so
  //   the combinational outputs show the new setting in the next
  //   cycle.
  // - a read returns data in the cycle after the strobe and only
  //   there; in every other cycle the read data are zero, so a bus
  //   that ors several slaves together needs no extra gating.
  // - index 3 is not implemented: it reads zero and ignores writes.
  // - selector codes at or above the number of wired sources pick a
  //   constant low, so a stale code never leaves a channel floating.
  // - the polarity stages are pure xor gates and add no latency to
  //   the gate or result paths of the cell.

  // register index decode
  logic                      hit_polarity;
  logic                      hit_data_one;
  logic                      hit_data_two;
  logic                      wr_polarity;
  logic                      wr_data_one;
  logic                      wr_data_two;

  // output invert, kept apart because every reset clears it
  logic                      output_invert_q;
  logic                      output_invert_d;

  // gate inverts and selectors, cleared by the cold reset only
  logic [`GATE_INV_MSB:0]    gate_invert_q;
  logic [`GATE_INV_MSB:0]    gate_invert_d;
  source_sel_t               data_one_source_q;
  source_sel_t               data_one_source_d;
  source_sel_t               data_two_source_q;
  source_sel_t               data_two_source_d;

  // read path
  reg_data_t                 rdata_q;
  reg_data_t                 rdata_d;
  reg_data_t                 polarity_view;
  reg_data_t                 data_one_view;
  reg_data_t                 data_two_view;

  // source vector padded to the full selector range
  logic [63:0]               src_ext;

  // one hit per implemented register, index 3 hits none
  assign hit_polarity = (addr_i == `POLARITY_OFS);
  assign hit_data_one = (addr_i == `DATA_ONE_SEL_OFS);
  assign hit_data_two = (addr_i == `DATA_TWO_SEL_OFS);

  // write strobes qualified per register
  assign wr_polarity  = wr_i & hit_polarity;
  assign wr_data_one  = wr_i & hit_data_one;
  assign wr_data_two  = wr_i & hit_data_two;

  // output invert takes bit 7 of a polarity write
  always_comb
  begin
    output_invert_d = output_invert_q;
    if (wr_polarity)
      output_invert_d = wdata_i[`OUT_INV_BIT]; // R6
  end

  // output invert register, cleared on every reset
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      output_invert_q <= `OUT_INV_RESET; // R5
    else
      output_invert_q <= output_invert_d;
  end

  // gate inverts take bits 3..0, bits 6..4 of the write are dropped
  always_comb
  begin
    gate_invert_d = gate_invert_q;
    if (wr_polarity)
      gate_invert_d = wdata_i[`GATE_INV_MSB:0]; // R1 R4
  end

  // gate invert register, survives warm resets
  always_ff @(posedge core_clk_i or negedge cold_rstn_i)
  begin
    if (!cold_rstn_i)
      gate_invert_q <= `GATE_INV_RESET; // R5
    else
      gate_invert_q <= gate_invert_d;
  end

  // data one selector takes bits 5..0, bits 7..6 are dropped
  always_comb
  begin
    data_one_source_d = data_one_source_q;
    if (wr_data_one)
      data_one_source_d = wdata_i[`SEL_MSB:0]; // R2 R4
  end

  // data one selector register, survives warm resets
  always_ff @(posedge core_clk_i or negedge cold_rstn_i)
  begin
    if (!cold_rstn_i)
      data_one_source_q <= `SEL_RESET; // R5
    else
      data_one_source_q <= data_one_source_d;
  end

  // data two selector takes bits 5..0, bits 7..6 are dropped
  always_comb
  begin
    data_two_source_d = data_two_source_q;
    if (wr_data_two)
      data_two_source_d = wdata_i[`SEL_MSB:0]; // R3 R4
  end

  // data two selector register, survives warm resets
  always_ff @(posedge core_clk_i or negedge cold_rstn_i)
  begin
    if (!cold_rstn_i)
      data_two_source_q <= `SEL_RESET; // R5
    else
      data_two_source_q <= data_two_source_d;
  end

  // read views, unimplemented bits tied to zero
  assign polarity_view = {output_invert_q, 3'h0, gate_invert_q}; // R4
  assign data_one_view = {2'h0, data_one_source_q}; // R4
  assign data_two_view = {2'h0, data_two_source_q}; // R4

  // read data chosen on the strobe, zero in every other cycle
  always_comb
  begin
    rdata_d = 8'h00;
    if (rd_i)
    begin
      unique case (addr_i)
        `POLARITY_OFS:     rdata_d = polarity_view;
        `DATA_ONE_SEL_OFS: rdata_d = data_one_view;
        `DATA_TWO_SEL_OFS: rdata_d = data_two_view;
        default:           rdata_d = 8'h00; // R4
      endcase
    end
  end

  // read data register, stands for the one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end
  assign rdata_o = rdata_q;

  // unimplemented source codes read as low
  generate
    if (NUM_SOURCES < 64)
    begin : g_pad
      assign src_ext = {{(64-NUM_SOURCES){1'b0}}, sources_i}; // R7
    end
    else
    begin : g_full
      assign src_ext = sources_i[63:0];
    end
  endgenerate

  // data channel muxes
  assign data_one_o    = src_ext[data_one_source_q]; // R2 R7
  assign data_two_o    = src_ext[data_two_source_q]; // R3 R7

  // one polarity stage per gate
  generate
    for (genvar g = 0; g <= `GATE_INV_MSB; g++)
    begin : g_gate
      assign gate_pol_o[g] = gate_raw_i[g] ^ gate_invert_q[g]; // R1
    end
  endgenerate

  // final polarity stage of the cell result
  assign cell_result_o = func_result_i ^ output_invert_q; // R6

endmodule

`default_nettype wire

// ===== test/cell_polarity_select_assertions.sv
// checker of the cell polarity and source select slice
`timescale 1ns/100ps
`default_nettype none
module cell_polarity_select_assertions
  import cell_cfg_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire reg_addr_t   addr_i,
  input wire reg_data_t   wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire reg_data_t   rdata_o,
  input wire logic [63:0] sources_i,
  input wire logic        data_one_o,
  input wire logic        data_two_o,
  input wire logic [3:0]  gate_raw_i,
  input wire logic [3:0]  gate_pol_o,
  input wire logic        func_result_i,
  input wire logic        cell_result_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_GATE_INV: assert property (wr_i && addr_i == 0 |=> gate_pol_o == (gate_raw_i ^ $past(wdata_i[3:0])))
    else $error("gate polarity wrong");
  AST_OUT_INV: assert property (wr_i && addr_i == 0 |=> cell_result_o == (func_result_i ^ $past(wdata_i[7])))
    else $error("cell result polarity wrong");
  AST_DATA_ONE: assert property (wr_i && addr_i == 1 |=> data_one_o == sources_i[$past(wdata_i[5:0])])
    else $error("data one source wrong");
  AST_DATA_TWO: assert property (wr_i && addr_i == 2 |=> data_two_o == sources_i[$past(wdata_i[5:0])])
    else $error("data two source wrong");
  AST_POL_GAP: assert property (rd_i && addr_i == 0 |=> rdata_o[6:4] == 0)
    else $error("polarity gap bits not zero");
  AST_SEL_GAP: assert property (rd_i && ^addr_i |=> rdata_o[7:6] == 0)
    else $error("selector gap bits not zero");
  AST_RST_OUT: assert property ($rose(rstn_i) |-> cell_result_o == func_result_i)
    else $error("output invert not cleared");
endmodule
bind cell_polarity_select cell_polarity_select_assertions chk (.*);
`default_nettype wire

// ===== test/logic_cell_polarity_input_select_tb_top.sv
// self-checking bench of the cell polarity and source select slice
`timescale 1ns/100ps
`default_nettype none
module logic_cell_polarity_input_select_tb_top;
  import cell_cfg_pkg::*;
  logic core_clk_i = 0, rstn_i = 0, cold_rstn_i = 0, wr_i = 0, rd_i = 0, func_result_i = 0;
  logic data_one_o, data_two_o, cell_result_o;
  logic [63:0] sources_i = 0;
  logic [3:0] gate_raw_i = 0, gate_pol_o;
  reg_addr_t addr_i = 0, a;
  reg_data_t wdata_i = 0, rdata_o, d, m[4] = '{0, 0, 0, 0}, k[4] = '{8'h8F, 8'h3F, 8'h3F, 0};
  int num_errors = 0, checks = 0, cyc = 0;
  cell_polarity_select dut (.*);
  initial forever #4 core_clk_i = ~core_clk_i;
  // cycle ceiling cuts a hang short
  always @(posedge core_clk_i) if (++cyc > 2000) begin num_errors++; finish_test; end
  task automatic cmp(input reg_data_t g, input reg_data_t e);
    checks++;
    if (g !== e) begin num_errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end
  endtask
  task finish_test;
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // random write then read back of one register, outputs checked beside it
  initial
  begin
    void'($urandom(32'hBACD));
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1; cold_rstn_i <= 1;
    for (int i = 1; i < 300; i++)
    begin
      if (i % 40 == 0)
      begin
        @(posedge core_clk_i) rstn_i <= 0;
        @(posedge core_clk_i) rstn_i <= 1;
        m[0][7] = 0;
      end
      a = $urandom; d = $urandom; m[a] = d & k[a];
      @(posedge core_clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
      sources_i <= {$urandom, $urandom}; gate_raw_i <= $urandom; func_result_i <= $urandom;
      @(posedge core_clk_i) {wr_i, rd_i} <= 2'b01;
      @(posedge core_clk_i) rd_i <= 0;
      #1 cmp(rdata_o, m[a]);
      cmp(gate_pol_o, gate_raw_i ^ m[0][3:0]);
      cmp(cell_result_o, func_result_i ^ m[0][7]);
      cmp(data_one_o, sources_i[m[1][5:0]]);
      cmp(data_two_o, sources_i[m[2][5:0]]);
    end
    finish_test;
  end
endmodule
`default_nettype wire
